// ### src/spb_pkg.sv
package spb_pkg;
    // number of slots served by one controller
    localparam int NUM_SLOTS       = 2;
    // fault delay in microseconds (plain default, sets the timer cap)
    localparam int FAULT_DELAY_US  = 1000;
    // system clock rate in MHz
    localparam int CLK_MHZ         = 40;
    // fault delay in cycles, exact product of time and clock rate
    localparam int FAULT_DELAY_CYC = FAULT_DELAY_US * CLK_MHZ;
    // control word bit positions for main and aux enables
    localparam int CTRL_MAIN_BIT   = 0;
    localparam int CTRL_AUX_BIT    = 1;
    // common status bit holding the interrupt mask
    localparam int CS_MASK_BIT     = 3;
    // status word fault bit positions
    localparam int STAT_MAIN_BIT   = 0;
    localparam int STAT_AUX_BIT    = 1;
    // slot breaker states
    typedef enum logic [1:0] {
        SPB_OFF,
        SPB_ON,
        SPB_TRIP
    } spb_state_e;
endpackage : spb_pkg

// ### src/spb_fault_timer.sv
`timescale 1ns/1ps
`default_nettype none
// fault delay counter: counts while overcurrent holds, clears when it drops
module spb_fault_timer #(
    parameter int TERM = spb_pkg::FAULT_DELAY_CYC
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // overcurrent level in, expiry level out
    input  wire logic over_current,
    output logic      expired
);
    localparam int W = $clog2(TERM + 1);
    // refuse a zero count at elaboration: the timer would expire with no delay
    if (TERM < 1) begin : g_bad_term
        $error("fault timer terminal count must be at least one");
    end
    logic [W-1:0] count;        // elapsed cycles of overcurrent
    logic [W-1:0] next_count;
    // saturating count, reset when the condition clears
    always_comb begin
        next_count = count;
        if (!over_current) begin
            next_count = '0;
        end else if (count != W'(TERM)) begin
            next_count = count + W'(1);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
    // registered compare keeps expiry glitch free
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            expired <= 1'b0;
        end else begin
            expired <= over_current && (next_count == W'(TERM));
        end
    end
endmodule : spb_fault_timer
`default_nettype wire

// ### src/spb_slot_power_breaker_control.sv
// What this block does
// - disabled slot: high gate up, low gate down
// - enable connects both gates to current drive
// - slow overcurrent past delay trips both mains
// - fast threshold shuts mains immediately
// - input undervoltage trips only while enabled
// - aux regulates, trips only after delay
// - disabling connects discharge to affected outputs
// - standby whenever a main input undervolts
// - aux independent of mains, runs in standby
// - mains on at undervoltage raise fault, interrupt
// - cycling the enable pin restarts after trip while its control bit is off
// - toggling control enable bits clears trip while the enable pin is low
// - fault pin only for pin-enabled outputs
// - interrupt with fault unless masked
// - writing one to the last set fault bit clears interrupt
// - interrupt mask bit one silences interrupt
`timescale 1ns/1ps
`default_nettype none
module spb_slot_power_breaker_control #(
    parameter int N         = spb_pkg::NUM_SLOTS,
    parameter int FLT_CYC   = spb_pkg::FAULT_DELAY_CYC
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // hot-plug pins, asynchronous
    input  wire logic [N-1:0] main_enable_in,
    input  wire logic [N-1:0] aux_enable_in,
    // management control bits (same clock)
    input  wire logic [N-1:0] ctrl_main_enable,
    input  wire logic [N-1:0] ctrl_aux_enable,
    input  wire logic         interrupt_mask,
    // echo-reset strobes, one per slot, write-one of fault bits
    input  wire logic [N-1:0] clear_main_fault,
    input  wire logic [N-1:0] clear_aux_fault,
    // analog comparators, asynchronous
    input  wire logic [N-1:0] high_rail_oc,
    input  wire logic [N-1:0] low_rail_oc,
    input  wire logic [N-1:0] high_rail_fast,
    input  wire logic [N-1:0] low_rail_fast,
    input  wire logic [N-1:0] aux_rail_oc,
    input  wire logic         high_supply_uv,
    input  wire logic         low_supply_uv,
    input  wire logic [N-1:0] standby_supply,
    // gate and switch controls
    output logic [N-1:0]      high_rail_gate_pullup,
    output logic [N-1:0]      high_rail_gate_sink,
    output logic [N-1:0]      low_rail_gate_hold,
    output logic [N-1:0]      low_rail_gate_source,
    output logic [N-1:0]      aux_rail_out,
    output logic [N-1:0]      aux_current_regulate,
    output logic [N-1:0]      main_discharge,
    output logic [N-1:0]      aux_discharge,
    // status
    output logic [N-1:0]      main_fault,
    output logic [N-1:0]      aux_fault,
    output logic              standby_mode,
    output logic [N-1:0]      fault_out_n,
    output logic              interrupt_out_n
);
    // refuse an empty slot bank at elaboration
    if (N < 1) begin : g_bad_n
        $error("slot count must be at least one");
    end
    // raw asynchronous inputs packed for one synchroniser bank
    localparam int SW = 8 * N + 2;
    logic [SW-1:0] raw_in;
    logic [SW-1:0] sync_a;      // first stage, read only by sync_b
    logic [SW-1:0] sync_b;      // safe to use
    assign raw_in = {main_enable_in, aux_enable_in, high_rail_oc, low_rail_oc,
                     high_rail_fast, low_rail_fast, aux_rail_oc, standby_supply,
                     high_supply_uv, low_supply_uv};
    // two flip-flop synchroniser for every comparator and pin
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end
    logic [N-1:0] pin_main, pin_aux, s_hoc, s_loc, s_hfast, s_lfast, s_aoc, s_stby;
    logic         s_huv, s_luv;
    assign {pin_main, pin_aux, s_hoc, s_loc, s_hfast, s_lfast, s_aoc, s_stby,
            s_huv, s_luv} = sync_b;
    // either main input low or absent puts the part in standby
    logic in_standby;
    assign in_standby = s_huv | s_luv;
    // per-slot registered state
    spb_pkg::spb_state_e main_st [N], next_main_st [N];
    spb_pkg::spb_state_e aux_st [N],  next_aux_st [N];
    logic [N-1:0] pin_main_q, pin_aux_q;      // enable source memory
    logic [N-1:0] next_main_fault, next_aux_fault;
    logic [N-1:0] next_pin_main, next_pin_aux;
    logic [N-1:0] main_dly, aux_dly;
    logic [N-1:0] req_main, req_aux;
    logic         next_irq_pend;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_slot
            // fault delay for either main rail and for the aux rail
            spb_fault_timer #(.TERM(FLT_CYC)) u_main_tmr (
                .clk_sys     (clk_sys),
                .sys_rst     (sys_rst),
                .over_current((s_hoc[g] | s_loc[g]) && main_st[g] == spb_pkg::SPB_ON),
                .expired     (main_dly[g])
            );
            spb_fault_timer #(.TERM(FLT_CYC)) u_aux_tmr (
                .clk_sys     (clk_sys),
                .sys_rst     (sys_rst),
                .over_current(s_aoc[g] && aux_st[g] == spb_pkg::SPB_ON),
                .expired     (aux_dly[g])
            );
            assign req_main[g] = pin_main[g] | ctrl_main_enable[g];
            assign req_aux[g]  = pin_aux[g] | ctrl_aux_enable[g];
            // breaker state, fault flags and enable source per slot
            always_comb begin
                next_main_st[g]    = main_st[g];
                next_aux_st[g]     = aux_st[g];
                next_main_fault[g] = main_fault[g];
                next_aux_fault[g]  = aux_fault[g];
                next_pin_main[g]   = pin_main_q[g];
                next_pin_aux[g]    = pin_aux_q[g];
                // echo reset clears first, so a new trip below still wins
                if (clear_main_fault[g]) begin
                    next_main_fault[g] = 1'b0;
                end
                if (clear_aux_fault[g]) begin
                    next_aux_fault[g] = 1'b0;
                end
                case (main_st[g])
                    spb_pkg::SPB_OFF: begin
                        // undervoltage holds the mains off but raises no fault while they are off
                        if (req_main[g] && !in_standby) begin
                            next_main_st[g]  = spb_pkg::SPB_ON;
                            next_pin_main[g] = pin_main[g];
                        end
                    end
                    spb_pkg::SPB_ON: begin
                        if (!req_main[g]) begin
                            next_main_st[g] = spb_pkg::SPB_OFF;
                        end else if (s_hfast[g] || s_lfast[g] || main_dly[g]
                                     || in_standby) begin
                            next_main_st[g]    = spb_pkg::SPB_TRIP;
                            next_main_fault[g] = 1'b1;
                        end
                    end
                    spb_pkg::SPB_TRIP: begin
                        // leaving trip needs the request dropped: pin and control bit both low
                        if (!req_main[g]) begin
                            next_main_st[g] = spb_pkg::SPB_OFF;
                        end
                    end
                    default: next_main_st[g] = spb_pkg::SPB_OFF;
                endcase
                case (aux_st[g])
                    spb_pkg::SPB_OFF: begin
                        // aux needs only the standby supply, not the mains
                        if (req_aux[g] && s_stby[g]) begin
                            next_aux_st[g]  = spb_pkg::SPB_ON;
                            next_pin_aux[g] = pin_aux[g];
                        end
                    end
                    spb_pkg::SPB_ON: begin
                        if (!req_aux[g] || !s_stby[g]) begin
                            next_aux_st[g] = spb_pkg::SPB_OFF;
                        end else if (aux_dly[g]) begin
                            next_aux_st[g]    = spb_pkg::SPB_TRIP;
                            next_aux_fault[g] = 1'b1;
                        end
                    end
                    spb_pkg::SPB_TRIP: begin
                        if (!req_aux[g]) begin
                            next_aux_st[g] = spb_pkg::SPB_OFF;
                        end
                    end
                    default: next_aux_st[g] = spb_pkg::SPB_OFF;
                endcase
            end
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    main_st[g] <= spb_pkg::SPB_OFF;
                    aux_st[g]  <= spb_pkg::SPB_OFF;
                end else begin
                    main_st[g] <= next_main_st[g];
                    aux_st[g]  <= next_aux_st[g];
                end
            end
            // gate drive: only the on state connects current drive
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    high_rail_gate_pullup[g] <= 1'b1;
                    high_rail_gate_sink[g]   <= 1'b0;
                    low_rail_gate_hold[g]    <= 1'b1;
                    low_rail_gate_source[g]  <= 1'b0;
                    aux_rail_out[g]          <= 1'b0;
                    aux_current_regulate[g]  <= 1'b0;
                    main_discharge[g]        <= 1'b1;
                    aux_discharge[g]         <= 1'b1;
                    fault_out_n[g]           <= 1'b1;
                end else begin
                    high_rail_gate_pullup[g] <= next_main_st[g] != spb_pkg::SPB_ON;
                    low_rail_gate_hold[g]    <= next_main_st[g] != spb_pkg::SPB_ON;
                    high_rail_gate_sink[g]   <= next_main_st[g] == spb_pkg::SPB_ON;
                    low_rail_gate_source[g]  <= next_main_st[g] == spb_pkg::SPB_ON;
                    aux_rail_out[g]          <= next_aux_st[g] == spb_pkg::SPB_ON;
                    // aux limits current instead of a fast trip
                    aux_current_regulate[g]  <= next_aux_st[g] == spb_pkg::SPB_ON
                                                && s_aoc[g];
                    main_discharge[g]        <= next_main_st[g] != spb_pkg::SPB_ON;
                    aux_discharge[g]         <= next_aux_st[g] != spb_pkg::SPB_ON;
                    // fault pin only reports pin-enabled breakers
                    fault_out_n[g] <= !((next_main_st[g] == spb_pkg::SPB_TRIP
                                         && next_pin_main[g])
                                        || (next_aux_st[g] == spb_pkg::SPB_TRIP
                                         && next_pin_aux[g]));
                end
            end
        end
    endgenerate
    // enable source and fault flags
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_main_q <= '0;
            pin_aux_q  <= '0;
            main_fault <= '0;
            aux_fault  <= '0;
        end else begin
            pin_main_q <= next_pin_main;
            pin_aux_q  <= next_pin_aux;
            main_fault <= next_main_fault;
            aux_fault  <= next_aux_fault;
        end
    end
    // interrupt pending while any fault flag stands
    always_comb begin
        next_irq_pend = |{next_main_fault, next_aux_fault};
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            interrupt_out_n <= 1'b1;
            standby_mode    <= 1'b0;
        end else begin
            interrupt_out_n <= !(next_irq_pend && !interrupt_mask);
            standby_mode    <= in_standby;
        end
    end
endmodule : spb_slot_power_breaker_control
`default_nettype wire

// ### test/spb_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module spb_checker #(
    parameter int N       = 2,
    parameter int FLT_CYC = 10
) (
    // clock and reset
    input wire logic         clk_sys,
    input wire logic         sys_rst,
    // control side
    input wire logic [N-1:0] ctrl_main_enable,
    input wire logic [N-1:0] main_enable_in,
    input wire logic         interrupt_mask,
    input wire logic [N-1:0] clear_main_fault,
    // comparators
    input wire logic [N-1:0] high_rail_oc,
    input wire logic [N-1:0] low_rail_oc,
    input wire logic [N-1:0] high_rail_fast,
    input wire logic [N-1:0] low_rail_fast,
    input wire logic [N-1:0] aux_rail_oc,
    input wire logic         high_supply_uv,
    input wire logic         low_supply_uv,
    // outputs under watch
    input wire logic [N-1:0] high_rail_gate_pullup,
    input wire logic [N-1:0] high_rail_gate_sink,
    input wire logic [N-1:0] low_rail_gate_hold,
    input wire logic [N-1:0] low_rail_gate_source,
    input wire logic [N-1:0] aux_rail_out,
    input wire logic [N-1:0] main_discharge,
    input wire logic [N-1:0] aux_discharge,
    input wire logic [N-1:0] main_fault,
    input wire logic [N-1:0] aux_fault,
    input wire logic         standby_mode,
    input wire logic         interrupt_out_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // raw run lengths; they lead the synchroniser, so bounds carry slack
    int  oc_cnt;   // main overcurrent on slot 1
    int  aux_cnt;  // aux overcurrent on slot 0
    wire uv = high_supply_uv || low_supply_uv;  // either main input low
    // count cycles of held overcurrent, clear when it drops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            oc_cnt  <= 0;
            aux_cnt <= 0;
        end else begin
            oc_cnt  <= (high_rail_oc[1] || low_rail_oc[1]) ? oc_cnt + 1 : 0;
            aux_cnt <= aux_rail_oc[0] ? aux_cnt + 1 : 0;
        end
    end
    property p_gate_pair;
        high_rail_gate_pullup == ~high_rail_gate_sink
            && low_rail_gate_hold == high_rail_gate_pullup
            && low_rail_gate_source == high_rail_gate_sink;
    endproperty
    a_gate_pair: assert property (p_gate_pair) else $error("gate outputs disagree");
    property p_ctrl_on;
        $rose(ctrl_main_enable[0]) && !standby_mode && !main_enable_in[0]
            && !high_rail_fast[0] && !low_rail_fast[0] |=> high_rail_gate_sink[0];
    endproperty
    a_ctrl_on: assert property (p_ctrl_on) else $error("control enable ignored");
    property p_fast;
        (high_rail_fast[0] || low_rail_fast[0]) && high_rail_gate_sink[0]
            |-> ##[1:4] !high_rail_gate_sink[0];
    endproperty
    a_fast: assert property (p_fast) else $error("fast trip late");
    property p_slow;
        oc_cnt == FLT_CYC + 6 |-> !high_rail_gate_sink[1];
    endproperty
    a_slow: assert property (p_slow) else $error("slow trip missing");
    property p_aux;
        $rose(aux_fault[0]) |-> aux_cnt >= FLT_CYC && aux_cnt <= FLT_CYC + 6;
    endproperty
    a_aux: assert property (p_aux) else $error("aux trip at wrong time");
    property p_discharge;
        main_discharge == high_rail_gate_pullup && aux_discharge == ~aux_rail_out;
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge wrong");
    property p_standby;
        uv [*5] |-> standby_mode;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");
    property p_uv_idle;
        uv && !high_rail_gate_sink[1] && !main_fault[1] |=> !main_fault[1];
    endproperty
    a_uv_idle: assert property (p_uv_idle) else $error("idle slot tripped");
    property p_int_on;
        $rose(main_fault[0]) && !interrupt_mask |-> ##[0:1] !interrupt_out_n;
    endproperty
    a_int_on: assert property (p_int_on) else $error("interrupt missing");
    property p_mask;
        interrupt_mask [*3] |-> interrupt_out_n;
    endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt active");
    property p_int_clr;
        clear_main_fault[0] && main_fault[0]
            && !(aux_fault[0] || main_fault[1] || aux_fault[1]) |=> interrupt_out_n;
    endproperty
    a_int_clr: assert property (p_int_clr) else $error("interrupt not cleared");
    // main scenarios reached
    c_slow: cover property ($rose(main_fault[1]));
    c_aux: cover property ($rose(aux_fault[0]));
    c_stby: cover property ($rose(standby_mode));
endmodule // spb_checker
bind spb_slot_power_breaker_control spb_checker #(.N(N), .FLT_CYC(FLT_CYC)) spb_checker_i (
    .clk_sys, .sys_rst, .ctrl_main_enable, .main_enable_in, .interrupt_mask,
    .clear_main_fault, .high_rail_oc, .low_rail_oc, .high_rail_fast, .low_rail_fast,
    .aux_rail_oc, .high_supply_uv, .low_supply_uv, .high_rail_gate_pullup,
    .high_rail_gate_sink, .low_rail_gate_hold, .low_rail_gate_source, .aux_rail_out,
    .main_discharge, .aux_discharge, .main_fault, .aux_fault, .standby_mode,
    .interrupt_out_n);
`default_nettype wire

// ### test/spb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// hot-plug controller: drives the slot enable pins from requests
module spb_host_model #(
    parameter int N = 2
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // requests from the sequence
    input  wire logic [N-1:0] main_req,
    input  wire logic [N-1:0] aux_req,
    input  wire logic         power_down,
    // slot enable pins
    output logic [N-1:0]      main_enable_in,
    output logic [N-1:0]      aux_enable_in
);
    // pins change only after an edge; a restart is a drop then a raise
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            main_enable_in <= '0;
            aux_enable_in  <= '0;
        end else begin
            // mains released ahead of a supply drop
            main_enable_in <= power_down ? '0 : main_req;
            aux_enable_in  <= aux_req;
        end
    end
endmodule // spb_host_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    localparam int FLT = 10;  // shortened fault delay keeps the run brief
    logic       clk_sys, sys_rst, interrupt_mask, high_supply_uv, low_supply_uv, power_down;
    logic [1:0] main_req, aux_req, main_enable_in, aux_enable_in, standby_supply;
    logic [1:0] ctrl_main_enable, ctrl_aux_enable, clear_main_fault, clear_aux_fault;
    logic [1:0] high_rail_oc, low_rail_oc, high_rail_fast, low_rail_fast, aux_rail_oc;
    logic [1:0] high_rail_gate_pullup, high_rail_gate_sink, low_rail_gate_hold;
    logic [1:0] low_rail_gate_source, aux_rail_out, aux_current_regulate;
    logic [1:0] main_discharge, aux_discharge, main_fault, aux_fault, fault_out_n;
    logic       standby_mode, interrupt_out_n;
    int         error_cnt = 0;
    int         checks = 0;
    spb_host_model #(.N(2)) spb_host_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .main_req(main_req), .aux_req(aux_req), .power_down(power_down),
        .main_enable_in(main_enable_in), .aux_enable_in(aux_enable_in));
    spb_slot_power_breaker_control #(.N(2), .FLT_CYC(FLT)) spb_slot_power_breaker_control_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .main_enable_in(main_enable_in),
        .aux_enable_in(aux_enable_in), .ctrl_main_enable(ctrl_main_enable),
        .ctrl_aux_enable(ctrl_aux_enable), .interrupt_mask(interrupt_mask),
        .clear_main_fault(clear_main_fault), .clear_aux_fault(clear_aux_fault),
        .high_rail_oc(high_rail_oc), .low_rail_oc(low_rail_oc), .high_rail_fast(high_rail_fast),
        .low_rail_fast(low_rail_fast), .aux_rail_oc(aux_rail_oc),
        .high_supply_uv(high_supply_uv), .low_supply_uv(low_supply_uv),
        .standby_supply(standby_supply), .high_rail_gate_pullup(high_rail_gate_pullup),
        .high_rail_gate_sink(high_rail_gate_sink), .low_rail_gate_hold(low_rail_gate_hold),
        .low_rail_gate_source(low_rail_gate_source), .aux_rail_out(aux_rail_out),
        .aux_current_regulate(aux_current_regulate), .main_discharge(main_discharge),
        .aux_discharge(aux_discharge), .main_fault(main_fault), .aux_fault(aux_fault),
        .standby_mode(standby_mode), .fault_out_n(fault_out_n),
        .interrupt_out_n(interrupt_out_n));
    // 40 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // wait n rising edges
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // verdict and stop
    task automatic end_sim();
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // watchdog, far beyond the roughly 150 cycles the sequence needs
    initial begin
        w(3000);
        error_cnt++;
        end_sim();
    end
    // main sequence: drive at rising edges, look at falling edges
    initial begin
        {sys_rst, interrupt_mask, high_supply_uv, low_supply_uv, power_down} = 5'h10;
        {main_req, aux_req, ctrl_main_enable, ctrl_aux_enable} = 8'h00;
        {clear_main_fault, clear_aux_fault, high_rail_oc, low_rail_oc} = 8'h00;
        {high_rail_fast, low_rail_fast, aux_rail_oc} = 6'h00;
        standby_supply = 2'h3;
        w(10); sys_rst <= 1'h0; @(negedge clk_sys);
        `CHK(high_rail_gate_pullup & low_rail_gate_hold, 2'h3)
        `CHK(main_discharge, 2'h3)
        `CHK(interrupt_out_n, 1'h1)
        w(1); ctrl_main_enable <= 2'h1; ctrl_aux_enable <= 2'h2; w(4); @(negedge clk_sys);
        `CHK(high_rail_gate_sink & low_rail_gate_source, 2'h1)
        `CHK(main_discharge, 2'h2)
        `CHK(aux_rail_out, 2'h2)
        w(1); low_rail_fast <= 2'h1; w(6); low_rail_fast <= 2'h0; @(negedge clk_sys);
        `CHK(high_rail_gate_sink, 2'h0)
        `CHK(main_fault, 2'h1)
        `CHK(interrupt_out_n, 1'h0)
        `CHK(fault_out_n, 2'h3)
        w(1); clear_main_fault <= 2'h1; w(1); clear_main_fault <= 2'h0; w(1); @(negedge clk_sys);
        `CHK(interrupt_out_n, 1'h1)
        `CHK(high_rail_gate_sink, 2'h0)
        w(1); ctrl_main_enable <= 2'h0; w(3); ctrl_main_enable <= 2'h1; w(3); @(negedge clk_sys);
        `CHK(high_rail_gate_sink, 2'h1)
        w(1); main_req <= 2'h2; w(6); @(negedge clk_sys);
        `CHK(high_rail_gate_sink, 2'h3)
        w(1); low_rail_oc <= 2'h2; w(FLT - 3); low_rail_oc <= 2'h0; w(6); @(negedge clk_sys);
        `CHK(high_rail_gate_sink, 2'h3)
        w(1); high_rail_oc <= 2'h2; w(FLT + 10); @(negedge clk_sys);
        `CHK(high_rail_gate_sink, 2'h1)
        `CHK(fault_out_n, 2'h1)
        `CHK(interrupt_out_n, 1'h0)
        `CHK(aux_rail_out, 2'h2)
        w(1); high_rail_oc <= 2'h0; clear_main_fault <= 2'h2; interrupt_mask <= 1'h1;
        w(1); clear_main_fault <= 2'h0; main_req <= 2'h0; w(4); main_req <= 2'h2;
        w(6); @(negedge clk_sys);
        `CHK(high_rail_gate_sink, 2'h3)
        w(1); high_rail_fast <= 2'h2; w(6); @(negedge clk_sys);
        `CHK(main_fault, 2'h2)
        `CHK(interrupt_out_n, 1'h1)
        w(1); high_rail_fast <= 2'h0; clear_main_fault <= 2'h2;
        w(1); clear_main_fault <= 2'h0; interrupt_mask <= 1'h0; aux_req <= 2'h1;
        w(6); @(negedge clk_sys);
        `CHK(aux_rail_out, 2'h3)
        w(1); aux_rail_oc <= 2'h1; w(FLT - 2); @(negedge clk_sys);
        `CHK(aux_current_regulate[0] & aux_rail_out[0], 1'h1)
        w(12); @(negedge clk_sys);
        `CHK(aux_rail_out, 2'h2)
        `CHK(aux_fault, 2'h1)
        `CHK(aux_discharge, 2'h1)
        `CHK(high_rail_gate_sink[0], 1'h1)
        w(1); aux_rail_oc <= 2'h0; clear_aux_fault <= 2'h1; w(1); clear_aux_fault <= 2'h0;
        power_down <= 1'h1; w(4); low_supply_uv <= 1'h1; high_supply_uv <= 1'h1;
        w(6); @(negedge clk_sys);
        `CHK(standby_mode, 1'h1)
        `CHK(main_fault, 2'h1)
        `CHK(interrupt_out_n, 1'h0)
        `CHK(aux_rail_out, 2'h2)
        // standby supply lost on slot 1 and aux pin dropped on the tripped slot 0
        w(1); standby_supply <= 2'h1; aux_req <= 2'h0; w(6); @(negedge clk_sys);
        `CHK(aux_rail_out, 2'h0)
        `CHK(aux_discharge, 2'h3)
        // supply back and aux pin raised again: both aux rails restart in standby
        w(1); standby_supply <= 2'h3; aux_req <= 2'h1; w(6); @(negedge clk_sys);
        `CHK(aux_rail_out, 2'h3)
        end_sim();
    end
endmodule // tb
`default_nettype wire
